// File: inc/pss_pkg.sv
// pss_pkg: register map, bit positions and reset values of the status summary upper half.
// assumes: one clock domain at 200 MHz, synchronous active-high reset.
package pss_pkg;
	localparam int PSS_AW = 5;
	localparam logic [4:0] PSS_OFF_BASIC_STATUS = 5'h01;
	localparam logic [4:0] PSS_OFF_AN_EXPANSION = 5'h06;
	localparam logic [4:0] PSS_OFF_SUMMARY = 5'h10;
	localparam logic [4:0] PSS_OFF_FC_COUNTER = 5'h14;
	localparam logic [4:0] PSS_OFF_RX_ERR_COUNTER = 5'h15;
	localparam logic [4:0] PSS_OFF_TENBASE_STATUS = 5'h1a;
	localparam logic [4:0] PSS_OFF_IRQ_STATUS = 5'h1c;
	localparam logic [4:0] PSS_OFF_IRQ_ENABLE = 5'h1d;
	localparam logic [4:0] PSS_OFF_IRQ_CLEAR = 5'h1e;
	localparam logic [4:0] PSS_OFF_CROSS_CTRL = 5'h1f;
	localparam int PSS_BIT_CROSSOVER = 14;
	localparam int PSS_BIT_RX_ERR = 13;
	localparam int PSS_BIT_POLARITY = 12;
	localparam int PSS_BIT_FALSE_CARRIER = 11;
	localparam int PSS_BIT_SIGNAL_DETECT = 10;
	localparam int PSS_BIT_DESCR_LOCK = 9;
	localparam int PSS_BIT_PAGE_RX = 8;
	localparam int PSS_BIT_REMOTE_FAULT = 6;
	localparam int PSS_TENBASE_POL_BIT = 4;
	localparam int PSS_AUTONEG_EXPANSION_REG_PAGE_BIT = 1;
	localparam int PSS_NUM_EVENTS = 5;
	localparam logic [15:0] PSS_RESET_SUMMARY = 16'h0000;
	localparam logic [4:0] PSS_RESET_IRQ_ENABLE = 5'h00;
	localparam logic [1:0] PSS_RESET_CROSS_CTRL = 2'h1;
endpackage : pss_pkg

// File: inc/pss_latch_if.sv
// pss_latch_if: bundle between the summary top and its latch bank.
// assumes: both ends share clk; read strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface pss_latch_if #(parameter int N = 4);
	logic [N-1:0] src;
	logic [N-1:0] clr;
	logic [N-1:0] q;
	modport top (output src, output clr, input q);
	modport bank (input src, input clr, output q);
endinterface : pss_latch_if
`default_nettype wire

// File: src/pss_latch_bank.sv
// pss_latch_bank: a row of latch-high or latch-low status holders.
// assumes: clr is a one-cycle read pulse from the owning register.
`timescale 1ns/1ps
`default_nettype none
module pss_latch_bank import pss_pkg::*; #(
	parameter int N = 4,
	parameter logic [N-1:0] LATCH_LOW = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	pss_latch_if.bank lb
);
	logic [N-1:0] held_q;
	logic [N-1:0] held_d;
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			// latched level wins over a read in the same cycle
			wire logic active = LATCH_LOW[i] ? ~lb.src[i] : lb.src[i];
			wire logic live = lb.src[i];
			assign held_d[i] = active ? 1'b1 : (lb.clr[i] ? 1'b0 : held_q[i]);
			assign lb.q[i] = LATCH_LOW[i] ? (live & ~held_q[i]) : (live | held_q[i]);
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (sys_rst)
			held_q <= '0;
		else if (clk_en)
			held_q <= held_d;
	end
endmodule : pss_latch_bank
`default_nettype wire

// File: src/pss_status_summary.sv
// pss_status_summary: upper half (15..6) of the transceiver status summary register.
// assumes: event and status inputs come from core logic on clk; register port strobes are one cycle.
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - bits 15 and 7 read zero, writes ignored
// - bit 14 reports crossover state, one means pairs swapped
// - crossover bit follows auto swaps when enabled and not forced
// - bit 13 latches receive errors, cleared by reading 0x15
// - bit 12 mirrors 10 Mb/s status polarity bit 4
// - polarity copy clears on 10 Mb/s status read, not summary read
// - bit 11 latches false carrier, cleared by reading 0x14
// - bit 10 signal detect, latch-low, resets to zero
// - bit 9 descrambler lock, latch-low, resets to zero
// - bit 8 copies page received, cleared by expansion read
// - summary read does not clear page received copy
// - bit 6 remote fault, cleared by basic status read or reset
`timescale 1ns/1ps
`default_nettype none
module pss_status_summary import pss_pkg::*; #(
	parameter logic [1:0] CROSS_CTRL_RESET = PSS_RESET_CROSS_CTRL
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic auto_swap,
	input wire logic rx_error_event,
	input wire logic polarity_inverted,
	input wire logic false_carrier_event,
	input wire logic signal_detect,
	input wire logic descrambler_lock,
	input wire logic page_received_event,
	input wire logic remote_fault_event,
	output logic crossover_swapped,
	output logic irq
);
	//------------------------------------------------------------
	// register decode
	//------------------------------------------------------------
	wire logic rd_basic = reg_rd & (reg_addr == PSS_OFF_BASIC_STATUS);
	wire logic rd_autoneg_expansion_reg = reg_rd & (reg_addr == PSS_OFF_AN_EXPANSION);
	wire logic rd_sum = reg_rd & (reg_addr == PSS_OFF_SUMMARY);
	wire logic rd_fcc = reg_rd & (reg_addr == PSS_OFF_FC_COUNTER);
	wire logic rd_rec = reg_rd & (reg_addr == PSS_OFF_RX_ERR_COUNTER);
	wire logic rd_tenb = reg_rd & (reg_addr == PSS_OFF_TENBASE_STATUS);
	wire logic rd_ists = reg_rd & (reg_addr == PSS_OFF_IRQ_STATUS);
	wire logic rd_ien = reg_rd & (reg_addr == PSS_OFF_IRQ_ENABLE);
	wire logic rd_cross = reg_rd & (reg_addr == PSS_OFF_CROSS_CTRL);
	wire logic wr_ien = reg_wr & (reg_addr == PSS_OFF_IRQ_ENABLE);
	wire logic wr_iclr = reg_wr & (reg_addr == PSS_OFF_IRQ_CLEAR);
	wire logic wr_cross = reg_wr & (reg_addr == PSS_OFF_CROSS_CTRL);

	//------------------------------------------------------------
	// crossover control and state
	//------------------------------------------------------------
	// bit0 auto enable, bit1 force swapped
	logic [1:0] cross_ctrl_q;
	logic swap_q;
	wire logic crossover_auto_enable = cross_ctrl_q[0];
	wire logic crossover_force = cross_ctrl_q[1];
	// force wins over the automatic algorithm
	wire logic swap_d = crossover_force ? 1'b1 : (crossover_auto_enable ? auto_swap : 1'b0);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cross_ctrl_q <= CROSS_CTRL_RESET;
			swap_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_cross)
				cross_ctrl_q <= reg_wdata[1:0];
			swap_q <= swap_d;
		end
	end
	assign crossover_swapped = swap_q;

	//------------------------------------------------------------
	// sticky copies set by events, cleared by reads of their owners
	//------------------------------------------------------------
	logic rx_err_q;
	logic pol_q;
	logic fc_q;
	logic page_q;
	logic rfault_q;
	// set wins over the clearing read in the same cycle
	wire logic rx_err_d = rx_error_event | (rx_err_q & ~rd_rec);
	wire logic fc_d = false_carrier_event | (fc_q & ~rd_fcc);
	// summary reads deliberately absent from these clear terms
	wire logic pol_d = polarity_inverted | (pol_q & ~rd_tenb);
	wire logic page_d = page_received_event | (page_q & ~rd_autoneg_expansion_reg);
	wire logic rfault_d = remote_fault_event | (rfault_q & ~rd_basic);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_err_q <= 1'b0;
			pol_q <= 1'b0;
			fc_q <= 1'b0;
			page_q <= 1'b0;
			rfault_q <= 1'b0;
		end else if (clk_en) begin
			rx_err_q <= rx_err_d;
			pol_q <= pol_d;
			fc_q <= fc_d;
			page_q <= page_d;
			rfault_q <= rfault_d;
		end
	end

	//------------------------------------------------------------
	// latch-low pmd indications
	//------------------------------------------------------------
	logic sd_live_q;
	logic lock_live_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sd_live_q <= 1'b0;
			lock_live_q <= 1'b0;
		end else if (clk_en) begin
			sd_live_q <= signal_detect;
			lock_live_q <= descrambler_lock;
		end
	end
	pss_latch_if #(.N(2)) ll ();
	assign ll.src = {lock_live_q, sd_live_q};
	assign ll.clr = {2{rd_sum}};
	pss_latch_bank #(.N(2), .LATCH_LOW(2'h3)) u_ll (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.lb(ll)
	);

	//------------------------------------------------------------
	// summary word
	//------------------------------------------------------------
	logic [15:0] summary;
	always_comb begin
		summary = PSS_RESET_SUMMARY;
		summary[PSS_BIT_CROSSOVER] = swap_q;
		summary[PSS_BIT_RX_ERR] = rx_err_q;
		summary[PSS_BIT_POLARITY] = pol_q;
		summary[PSS_BIT_FALSE_CARRIER] = fc_q;
		summary[PSS_BIT_SIGNAL_DETECT] = ll.q[0];
		summary[PSS_BIT_DESCR_LOCK] = ll.q[1];
		summary[PSS_BIT_PAGE_RX] = page_q;
		summary[PSS_BIT_REMOTE_FAULT] = rfault_q;
	end

	//------------------------------------------------------------
	// interrupts
	//------------------------------------------------------------
	// events: rx error, false carrier, page received, remote fault, link signal lost
	logic [4:0] ists_q;
	logic [4:0] ien_q;
	logic sd_prev_q;
	wire logic sd_fall = sd_prev_q & ~sd_live_q;
	wire logic [4:0] ev = {sd_fall, remote_fault_event, page_received_event, false_carrier_event, rx_error_event};
	wire logic [4:0] iclr = wr_iclr ? reg_wdata[4:0] : 5'h00;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ists_q <= '0;
			ien_q <= PSS_RESET_IRQ_ENABLE;
			sd_prev_q <= 1'b0;
		end else if (clk_en) begin
			ists_q <= ev | (ists_q & ~iclr);
			if (wr_ien)
				ien_q <= reg_wdata[4:0];
			sd_prev_q <= sd_live_q;
		end
	end
	assign irq = |(ists_q & ien_q);

	//------------------------------------------------------------
	// read data, one cycle after the strobe
	//------------------------------------------------------------
	wire logic [15:0] rd_mux = rd_sum ? summary :
		rd_ists ? {11'h000, ists_q} :
		rd_ien ? {11'h000, ien_q} :
		rd_cross ? {14'h0000, cross_ctrl_q} :
		rd_tenb ? {11'h000, pol_q, 4'h0} :
		rd_autoneg_expansion_reg ? {14'h0000, page_q, 1'b0} :
		16'h0000;
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (clk_en)
			reg_rdata <= rd_mux;
	end
endmodule : pss_status_summary
`default_nettype wire

// File: dv/pss_status_summary_properties.sv
// pss_status_summary_properties: port-level checks of the status summary upper half.
// assumes: bound to pss_status_summary with clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module pss_status_summary_properties import pss_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic rx_error_event,
	input wire logic polarity_inverted,
	input wire logic signal_detect,
	input wire logic page_received_event,
	input wire logic remote_fault_event,
	input wire logic crossover_swapped
);
	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire sum_rd = reg_rd && reg_addr == PSS_OFF_SUMMARY;
	a_reserved_read_zero: assert property (!reg_rdata[15] && !reg_rdata[7]) else $error("reserved bit set");
	a_swap_on_read: assert property (sum_rd |=> reg_rdata[14] == $past(crossover_swapped)) else $error("bit 14");
	a_rxerr_sets: assert property (rx_error_event ##1 sum_rd |=> reg_rdata[13]) else $error("rx error not set");
	a_rxerr_clears: assert property (reg_rd && reg_addr == PSS_OFF_RX_ERR_COUNTER && !rx_error_event ##1 sum_rd
		|=> !reg_rdata[13]) else $error("rx error kept");
	a_pol_clears: assert property (reg_rd && reg_addr == PSS_OFF_TENBASE_STATUS && !polarity_inverted ##1 sum_rd
		|=> !reg_rdata[12]) else $error("polarity kept");
	a_page_keeps: assert property (sum_rd ##1 sum_rd && reg_rdata[8] |=> reg_rdata[8]) else $error("page lost");
	a_fault_clears: assert property (reg_rd && reg_addr == PSS_OFF_BASIC_STATUS && !remote_fault_event ##1 sum_rd
		|=> !reg_rdata[6]) else $error("fault kept");
	a_low_drop_held: assert property (!signal_detect ##2 sum_rd |=> !reg_rdata[10]) else $error("drop lost");
endmodule : pss_status_summary_properties
`default_nettype wire

// File: dv/pss_status_summary_tb.sv
// pss_status_summary_tb: self-checking bench, per-cycle model of the summary.
// assumes: pss_pkg compiled first; clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module pss_status_summary_tb import pss_pkg::*; ;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, crossover_swapped, irq, sdr, dlr, known;
	logic [4:0] reg_addr = '0, ev = '0, en, st;
	logic [15:0] reg_wdata = '0, reg_rdata, ex, em, ms;
	logic [2:0] lvl = '0;
	logic [1:0] ctrl;
	logic [4:0] ca [5] = '{5'h1a, 5'h15, 5'h14, 5'h06, 5'h01};
	logic [4:0] ra [11] = '{5'h10, 5'h15, 5'h14, 5'h1a, 5'h06, 5'h01, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h03};
	int failures = 0, tests_run = 0, i, j;
	always #2.5 clk = ~clk;
	pss_status_summary dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_swap(lvl[0]), .rx_error_event(ev[1]),
		.polarity_inverted(ev[0]), .false_carrier_event(ev[2]), .signal_detect(lvl[2]), .descrambler_lock(lvl[1]),
		.page_received_event(ev[3]), .remote_fault_event(ev[4]), .crossover_swapped(crossover_swapped), .irq(irq));
	//----------------------------------------
	// model and comparison
	//----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("Error %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	always @(negedge clk) if (!sys_rst) begin
		chk(reg_rdata & em, ex & em);
		chk({15'h0, irq}, {15'h0, |(st & en)});
		chk({15'h0, crossover_swapped}, {15'h0, ms[14]});
	end
	// e = {fault, page, false carrier, rx error, polarity}
	task automatic step(input logic rd, input logic wr, input logic [4:0] a, input logic [15:0] wd, input logic [4:0] e);
		reg_rd <= rd;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= wd;
		ev <= e;
		@(posedge clk);
		// latch-low bits are unknown until the first summary read
		em = !rd ? 16'hffff : a == PSS_OFF_SUMMARY ? (known ? 16'hffff : 16'hf9ff) :
			a == PSS_OFF_IRQ_STATUS ? 16'h000f : a == 5'h03 ? 16'hffff : 16'h0000;
		ex = (rd && a == PSS_OFF_SUMMARY) ? ms : (rd && a == PSS_OFF_IRQ_STATUS) ? {11'h0, st} : 16'h0000;
		for (int k = 0; k < 5; k++) if (rd && a == ca[k]) ms[k == 0 ? 12 : k == 1 ? 13 : k == 2 ? 11 : k == 3 ? 8 : 6] = 0;
		// value after this edge: live sample just taken, gated by drops not yet read
		{ms[10], ms[9]} = ((rd && a == PSS_OFF_SUMMARY) ? {sdr, dlr} : {ms[10], ms[9]}) & lvl[2:1];
		known |= rd && a == PSS_OFF_SUMMARY;
		{sdr, dlr} = lvl[2:1];
		ms[14] = ctrl[1] | (ctrl[0] & lvl[0]);
		if (wr && a == PSS_OFF_CROSS_CTRL) ctrl = wd[1:0];
		if (wr && a == PSS_OFF_IRQ_ENABLE) en = wd[4:0];
		if (wr && a == PSS_OFF_IRQ_CLEAR) st &= ~wd[4:0];
		st |= {1'h0, e[4:1]};
		{ms[6], ms[8], ms[11], ms[13], ms[12]} = {ms[6], ms[8], ms[11], ms[13], ms[12]} | e;
	endtask : step
	task automatic rds();
		step(1'h1, 1'h0, PSS_OFF_SUMMARY, 16'h0000, 5'h00);
	endtask : rds
	task automatic idle();
		step(1'h0, 1'h0, 5'h00, 16'h0000, 5'h00);
	endtask : idle
	task automatic do_reset();
		{reg_rd, reg_wr, ev} <= '0;
		sys_rst <= 1'h1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		{ms, sdr, dlr, known, en, st, ex} = '0;
		em = '1;
		ctrl = PSS_RESET_CROSS_CTRL;
	endtask : do_reset
	task automatic done(input string s);
		$display("test %s finished, mismatches %0d", s, failures);
	endtask : done
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	//----------------------------------------
	// scenarios
	//----------------------------------------
	initial begin
		void'($urandom(7));
		do_reset();
		rds();
		step(1'h1, 1'h0, 5'h03, 16'h0000, 5'h00);
		done("reset");
		// event in the clearing read's cycle must survive it
		for (i = 0; i < 5; i++) begin
			step(1'h0, 1'h0, 5'h00, 16'h0000, 5'(1 << i));
			rds();
			rds();
			step(1'h1, 1'h0, ca[i], 16'h0000, 5'(1 << i));
			rds();
			step(1'h1, 1'h0, ca[i], 16'h0000, 5'h00);
			rds();
		end
		done("sticky");
		lvl <= 3'h6;
		repeat (3) idle();
		rds();
		rds();
		lvl <= 3'h0;
		idle();
		lvl <= 3'h6;
		idle();
		rds();
		idle();
		idle();
		rds();
		done("latch low");
		for (i = 0; i < 8; i++) begin
			lvl <= {2'h3, i[0]};
			step(1'h0, 1'h1, PSS_OFF_CROSS_CTRL, {14'h0, i[2:1]}, 5'h00);
			idle();
			rds();
		end
		step(1'h0, 1'h1, PSS_OFF_SUMMARY, 16'hffff, 5'h00);
		step(1'h0, 1'h1, PSS_OFF_RX_ERR_COUNTER, 16'hffff, 5'h00);
		rds();
		done("crossover");
		step(1'h0, 1'h1, PSS_OFF_IRQ_ENABLE, 16'h000f, 5'h02);
		idle();
		step(1'h0, 1'h1, PSS_OFF_IRQ_ENABLE, 16'h0000, 5'h00);
		step(1'h0, 1'h1, PSS_OFF_IRQ_ENABLE, 16'h0002, 5'h00);
		step(1'h1, 1'h0, PSS_OFF_IRQ_STATUS, 16'h0000, 5'h00);
		step(1'h0, 1'h1, PSS_OFF_IRQ_CLEAR, 16'h001f, 5'h00);
		idle();
		done("interrupt");
		// signal detect fall stays out of the enable mask: its timing is not modelled
		for (i = 0; i < 600; i++) begin
			j = $urandom % 4;
			lvl <= {2'h3, 1'($urandom)};
			step(j[0], j == 2, ra[$urandom % 11], 16'($urandom) & 16'hffef, ($urandom % 3 == 0) ? 5'($urandom) : 5'h00);
		end
		done("random");
		step(1'h0, 1'h0, 5'h00, 16'h0000, 5'h1f);
		do_reset();
		rds();
		done("second reset");
		conclude();
	end
endmodule : pss_status_summary_tb
bind pss_status_summary pss_status_summary_properties u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_error_event(rx_error_event), .polarity_inverted(polarity_inverted),
	.signal_detect(signal_detect), .page_received_event(page_received_event),
	.remote_fault_event(remote_fault_event), .crossover_swapped(crossover_swapped));
`default_nettype wire
